// ===== inc/ctfs_pkg.sv
package ctfs_pkg;
  // register map
  localparam logic [7:0] CTFS_ADDR_TEMP_ZONE = 8'h04;
  localparam logic [7:0] CTFS_ADDR_FAULTS_A = 8'h05;
  // field positions in latched_fault_flags_a
  localparam int CTFS_BIT_RELEASE = 7;
  localparam int CTFS_BIT_TIMER = 6;
  localparam int CTFS_BIT_BAT_OV = 5;
  localparam int CTFS_BIT_REG_FLT = 4;
  localparam int CTFS_BIT_DIE_HOT = 3;
  localparam int CTFS_BIT_SW_OC = 2;
  localparam int CTFS_BIT_IN_OV = 1;
  localparam int CTFS_BIT_IN_UV = 0;
  localparam int CTFS_NUM_FAULTS = 7;
  // mode encoding shared with the mode state machine
  localparam logic [1:0] CTFS_MODE_HIZ = 2'h0;
  localparam logic [1:0] CTFS_MODE_CHARGE = 2'h1;
  localparam logic [1:0] CTFS_MODE_REVERSE = 2'h2;
  // power-good thresholds in percent of target
  localparam int CTFS_PG_RISE_PCT = 92;
  localparam int CTFS_PG_FALL_PCT = 90;
  // temperature thresholds, degrees celsius
  localparam int CTFS_T_ZERO_C = 0;
  localparam int CTFS_T_MINUS10_C = -10;
  localparam int CTFS_T_COOL_HI_C = 10;
  localparam int CTFS_T_WARM_LO_C = 45;
  localparam int CTFS_T_HOT_C = 60;
  localparam int CTFS_T_HOT55_C = 55;
  localparam int CTFS_T_HOT65_C = 65;
  // restart delays
  localparam int CTFS_CLK_HZ = 20000000;
  localparam int CTFS_REG_RESTART_MS = 100;
  localparam int CTFS_OV_RESTART_SLOW_MS = 40;
  localparam int CTFS_OV_RESTART_FAST_US = 100;
  localparam int CTFS_REG_RESTART_CYC = CTFS_CLK_HZ / 1000 * CTFS_REG_RESTART_MS;
  localparam int CTFS_OV_SLOW_CYC = CTFS_CLK_HZ / 1000 * CTFS_OV_RESTART_SLOW_MS;
  localparam int CTFS_OV_FAST_CYC = CTFS_CLK_HZ / 1000000 * CTFS_OV_RESTART_FAST_US;
  localparam int CTFS_CNT_W = 22;
endpackage : ctfs_pkg

// ===== src/ctfs_delay_timer.sv
`timescale 1ns/1ns
// restart delay: loads on fault, counts down once the fault has gone
module ctfs_delay_timer #(
  parameter int CNT_W = 22
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  input wire logic fault_in,
  input wire logic [CNT_W-1:0] load_value_in,
  output logic expired_out
);
  logic [CNT_W-1:0] count_reg;
  logic [CNT_W-1:0] count_next;
  logic expired_reg;

  assign count_next = fault_in ? load_value_in :
                      (count_reg != '0) ? count_reg - 1'b1 : count_reg;
  assign expired_out = expired_reg;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      count_reg <= '0;
      expired_reg <= 1'b1;
    end else begin
      count_reg <= count_next;
      expired_reg <= !fault_in && (count_next == '0);
    end
  end
endmodule : ctfs_delay_timer

// ===== src/ctfs_status.sv
`timescale 1ns/1ns
// Notes on behaviour
// - power good sets above 92%, clears below 90%
// - reverse uses reverse target and input pin
// - battery present zero while thermistor sensing off
// - cold stop below 0 or -10 C
// - hot stop above 55, 60 or 65 C
// - profile on: below 0 C sets charge cold
// - profile on: 0..10 C cool, action field applied
// - profile on: 45..60 C warm, action field applied
// - profile on: above 60 C sets charge hot
// - charge cold, cool, warm, charge hot flags zero while profile disabled
// - writing release one drops interrupt, self clears
// - persisting fault may keep interrupt asserted
// - timer expiry latched in charge, read clears
// - expired timer sets flag again after read
// - battery overvoltage latched in charge, read clears
// - regulator fault latched, masks ignored, read clears
// - regulator clear waits 100 ms restart delay
// - die overheat clears only when condition gone
// - switch overcurrent clears only when condition gone
// - input overvoltage clears after selected restart delay
// - input undervoltage latched in charge, read clears
// - restart select: 0 is 40 ms, 1 is 100 us
module ctfs_status
  import ctfs_pkg::*;
#(
  parameter int TEMP_W = 8,
  parameter int VOLT_W = 12,
  parameter int REG_RESTART_CYC = CTFS_REG_RESTART_CYC,
  parameter int OV_SLOW_CYC = CTFS_OV_SLOW_CYC,
  parameter int OV_FAST_CYC = CTFS_OV_FAST_CYC
) (
  input wire logic clock_in,
  input wire logic rst_n_in,
  // register port from the serial interface, same clock
  input wire logic [7:0] reg_addr_in,
  input wire logic reg_wr_in,
  input wire logic reg_rd_in,
  input wire logic [7:0] reg_wdata_in,
  output logic [7:0] reg_rdata_out,
  // mode and settings
  input wire logic [1:0] op_mode_in,
  input wire logic thermistor_sense_off_in,
  input wire logic temp_profile_off_in,
  input wire logic cold_threshold_select_in,
  input wire logic [1:0] hot_threshold_select_in,
  input wire logic [1:0] cool_action_in,
  input wire logic [3:0] warm_action_in,
  input wire logic overvoltage_restart_select_in,
  input wire logic regulator_fault_mask_charge_in,
  input wire logic regulator_fault_mask_reverse_in,
  // analog measurements (pins, synchronised here)
  input wire logic signed [TEMP_W-1:0] battery_temp_in,
  input wire logic battery_detect_in,
  input wire logic [VOLT_W-1:0] reverse_output_target_in,
  input wire logic [VOLT_W-1:0] input_pin_volt_in,
  input wire logic [VOLT_W-1:0] termination_voltage_in,
  input wire logic [VOLT_W-1:0] battery_sense_pin_in,
  // raw fault conditions (pins)
  input wire logic timer_expired_in,
  input wire logic battery_ov_in,
  input wire logic regulator_fault_in,
  input wire logic die_overheat_in,
  input wire logic switch_oc_in,
  input wire logic input_ov_in,
  input wire logic input_uv_in,
  // outputs
  output logic interrupt_out_n,
  output logic charge_stop_out,
  output logic reverse_stop_out,
  output logic [1:0] cool_action_out,
  output logic [3:0] warm_action_out
);
  // ==========================================
  // elaboration checks
  // every restart count must fit the CTFS_CNT_W-bit delay counters
  if (TEMP_W < 8 || VOLT_W < 8 || REG_RESTART_CYC < 1 || OV_FAST_CYC < 1 ||
      OV_SLOW_CYC < 1 || OV_FAST_CYC >= (1 << CTFS_CNT_W) ||
      OV_SLOW_CYC >= (1 << CTFS_CNT_W) ||
      REG_RESTART_CYC >= (1 << CTFS_CNT_W)) begin : g_bad_param
    $error("ctfs_status: unsupported parameter values");
  end

  // ==========================================
  // input synchronisers
  localparam int SYNC_W = 7 + 1 + TEMP_W + 4 * VOLT_W;
  logic [SYNC_W-1:0] sync1_reg;
  logic [SYNC_W-1:0] sync2_reg;
  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      sync1_reg <= '0;
      sync2_reg <= '0;
    end else begin
      sync1_reg <= {timer_expired_in, battery_ov_in, regulator_fault_in, die_overheat_in,
                    switch_oc_in, input_ov_in, input_uv_in, battery_detect_in,
                    battery_temp_in, reverse_output_target_in, input_pin_volt_in,
                    termination_voltage_in, battery_sense_pin_in};
      sync2_reg <= sync1_reg;
    end
  end
  wire [6:0] cond_w = sync2_reg[SYNC_W-1 -: 7];
  wire bat_det_w = sync2_reg[SYNC_W-8];
  wire signed [TEMP_W-1:0] temp_w = sync2_reg[4*VOLT_W +: TEMP_W];
  wire [VOLT_W-1:0] rev_tgt_w = sync2_reg[3*VOLT_W +: VOLT_W];
  wire [VOLT_W-1:0] vin_w = sync2_reg[2*VOLT_W +: VOLT_W];
  wire [VOLT_W-1:0] termination_voltage_w = sync2_reg[VOLT_W +: VOLT_W];
  wire [VOLT_W-1:0] battery_sense_pin_w = sync2_reg[0 +: VOLT_W];

  // ==========================================
  // mode decode
  function automatic logic mode_is(input logic [1:0] mode, input logic [1:0] want);
    return mode == want;
  endfunction : mode_is
  wire chg_w = mode_is(op_mode_in, CTFS_MODE_CHARGE);
  wire rev_w = mode_is(op_mode_in, CTFS_MODE_REVERSE);
  wire profile_on_w = chg_w && !temp_profile_off_in;
  wire stop_zone_w = rev_w || (chg_w && temp_profile_off_in);

  // ==========================================
  // power good with hysteresis
  // source select
  wire [VOLT_W-1:0] pg_meas_w = rev_w ? vin_w : battery_sense_pin_w;
  wire [VOLT_W-1:0] pg_tgt_w = rev_w ? rev_tgt_w : termination_voltage_w;
  // products widened so 100 * measurement cannot wrap
  wire [VOLT_W+7:0] meas_x100_w = (VOLT_W + 8)'(pg_meas_w) * (VOLT_W + 8)'(100);
  wire [VOLT_W+7:0] rise_w = (VOLT_W + 8)'(pg_tgt_w) * (VOLT_W + 8)'(CTFS_PG_RISE_PCT);
  wire [VOLT_W+7:0] fall_w = (VOLT_W + 8)'(pg_tgt_w) * (VOLT_W + 8)'(CTFS_PG_FALL_PCT);
  wire pg_active_w = chg_w || rev_w;
  logic pg_reg;
  logic pg_next;
  assign pg_next = !pg_active_w ? 1'b0 :
                   (meas_x100_w > rise_w) ? 1'b1 :
                   (meas_x100_w < fall_w) ? 1'b0 : pg_reg;

  // ==========================================
  // temperature zones
  wire signed [TEMP_W-1:0] t_zero = TEMP_W'(CTFS_T_ZERO_C);
  wire signed [TEMP_W-1:0] t_m10 = TEMP_W'(CTFS_T_MINUS10_C);
  wire signed [TEMP_W-1:0] t_cool = TEMP_W'(CTFS_T_COOL_HI_C);
  wire signed [TEMP_W-1:0] t_warm = TEMP_W'(CTFS_T_WARM_LO_C);
  wire signed [TEMP_W-1:0] t_hot = TEMP_W'(CTFS_T_HOT_C);
  wire signed [TEMP_W-1:0] t_hot55 = TEMP_W'(CTFS_T_HOT55_C);
  wire signed [TEMP_W-1:0] t_hot65 = TEMP_W'(CTFS_T_HOT65_C);
  wire signed [TEMP_W-1:0] cold_lim_w = cold_threshold_select_in ? t_m10 : t_zero;
  // code 3 is treated as the 65 C threshold
  wire signed [TEMP_W-1:0] hot_lim_w = (hot_threshold_select_in == 2'h0) ? t_hot55 :
                                       (hot_threshold_select_in == 2'h1) ? t_hot : t_hot65;
  wire rcold_w = stop_zone_w && (temp_w < cold_lim_w);
  wire rhot_w = stop_zone_w && (temp_w > hot_lim_w);
  wire ccold_w = profile_on_w && (temp_w < t_zero);
  wire ccool_w = profile_on_w && (temp_w >= t_zero) && (temp_w < t_cool);
  wire cwarm_w = profile_on_w && (temp_w >= t_warm) && (temp_w <= t_hot);
  wire chot_w = profile_on_w && (temp_w > t_hot);
  wire bat_w = bat_det_w && !thermistor_sense_off_in;
  wire [7:0] zone_next = {pg_next, bat_w, rcold_w, rhot_w, ccold_w, ccool_w, cwarm_w, chot_w};
  logic [7:0] zone_reg;

  // ==========================================
  // latched faults
  wire rd_fault_w = reg_rd_in && (reg_addr_in == CTFS_ADDR_FAULTS_A);
  wire rd_zone_w = reg_rd_in && (reg_addr_in == CTFS_ADDR_TEMP_ZONE);
  wire wr_fault_w = reg_wr_in && (reg_addr_in == CTFS_ADDR_FAULTS_A);
  wire any_mode_w = chg_w || rev_w;
  wire reg_dly_done_w;
  wire ov_dly_done_w;
  wire [CTFS_CNT_W-1:0] ov_load_w = overvoltage_restart_select_in ?
                                    CTFS_CNT_W'(OV_FAST_CYC) : CTFS_CNT_W'(OV_SLOW_CYC);

  ctfs_delay_timer #(.CNT_W(CTFS_CNT_W)) u_reg_delay (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .fault_in(cond_w[CTFS_BIT_REG_FLT]),
    .load_value_in(CTFS_CNT_W'(REG_RESTART_CYC)),
    .expired_out(reg_dly_done_w)
  );
  ctfs_delay_timer #(.CNT_W(CTFS_CNT_W)) u_ov_delay (
    .clock_in(clock_in),
    .rst_n_in(rst_n_in),
    .fault_in(cond_w[CTFS_BIT_IN_OV]),
    .load_value_in(ov_load_w),
    .expired_out(ov_dly_done_w)
  );

  // charge-only, masks not used, either mode
  wire [6:0] fault_en_w = {chg_w, chg_w, any_mode_w, any_mode_w, any_mode_w, chg_w, chg_w};
  // a read clears only when allowed
  wire [6:0] clr_ok_w = {1'b1, 1'b1, reg_dly_done_w, !cond_w[CTFS_BIT_DIE_HOT],
                         !cond_w[CTFS_BIT_SW_OC], ov_dly_done_w, 1'b1};
  logic [6:0] fault_reg;
  logic [6:0] fault_next;
  genvar gi;
  generate
    for (gi = 0; gi < CTFS_NUM_FAULTS; gi++) begin : g_fault
      wire set_w = fault_en_w[gi] && cond_w[gi];
      assign fault_next[gi] = set_w ? 1'b1 :
                              (rd_fault_w && clr_ok_w[gi]) ? 1'b0 : fault_reg[gi];
    end
  endgenerate

  // ==========================================
  // interrupt
  logic irq_reg;
  logic irq_next;
  wire new_fault_w = |(fault_next & ~fault_reg);
  // release clears, an enabled fault condition still present re-asserts
  assign irq_next = (wr_fault_w && reg_wdata_in[CTFS_BIT_RELEASE]) ?
                    (|(fault_en_w & cond_w)) : (irq_reg || new_fault_w);

  // ==========================================
  // read data
  // release bit always reads 0
  wire [7:0] rdata_next = rd_zone_w ? zone_reg :
                          rd_fault_w ? {1'b0, fault_reg} : 8'h00;

  always_ff @(posedge clock_in or negedge rst_n_in) begin
    if (!rst_n_in) begin
      pg_reg <= 1'b0;
      zone_reg <= 8'h00;
      fault_reg <= '0;
      irq_reg <= 1'b0;
      reg_rdata_out <= 8'h00;
      interrupt_out_n <= 1'b1;
      charge_stop_out <= 1'b0;
      reverse_stop_out <= 1'b0;
      cool_action_out <= 2'h0;
      warm_action_out <= 4'h0;
    end else begin
      pg_reg <= pg_next;
      zone_reg <= zone_next;
      fault_reg <= fault_next;
      irq_reg <= irq_next;
      reg_rdata_out <= rdata_next;
      interrupt_out_n <= !irq_next;
      charge_stop_out <= chg_w && (rcold_w || rhot_w || ccold_w || chot_w);
      reverse_stop_out <= rev_w && (rcold_w || rhot_w);
      cool_action_out <= ccool_w ? cool_action_in : 2'h0;
      warm_action_out <= cwarm_w ? warm_action_in : 4'h0;
    end
  end

  // ==========================================
  // checks
  sequence s_release_wr;
    wr_fault_w && reg_wdata_in[CTFS_BIT_RELEASE];
  endsequence
  sequence s_fault_live;
    |(fault_en_w & cond_w);
  endsequence
  a_profile_off_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    temp_profile_off_in |=> zone_reg[3:0] == 4'h0)
    else $error("zone flag set with profile off");
  a_bat_present_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    thermistor_sense_off_in ##1 thermistor_sense_off_in |-> !zone_reg[6])
    else $error("battery present with sensing off");
  a_set_wins_clear: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (rd_fault_w && chg_w && cond_w[CTFS_BIT_IN_UV]) |=> fault_reg[CTFS_BIT_IN_UV])
    else $error("event lost on read clear");
  a_die_hot_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_reg[CTFS_BIT_DIE_HOT] && cond_w[CTFS_BIT_DIE_HOT]) |=> fault_reg[CTFS_BIT_DIE_HOT])
    else $error("die overheat cleared while present");
  a_release_drops: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (s_release_wr ##0 !(|(fault_en_w & cond_w))) |=> interrupt_out_n)
    else $error("interrupt not released");
  a_release_held: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (s_release_wr ##0 s_fault_live) |=> !interrupt_out_n)
    else $error("interrupt released with fault present");
  a_uv_read_clears: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (rd_fault_w && !cond_w[CTFS_BIT_IN_UV]) |=> !fault_reg[CTFS_BIT_IN_UV])
    else $error("undervoltage not cleared by read");
  a_uv_charge_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!chg_w && !fault_reg[CTFS_BIT_IN_UV]) |=> !fault_reg[CTFS_BIT_IN_UV])
    else $error("undervoltage latched outside charge");
  a_timer_charge_only: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (!chg_w && !fault_reg[CTFS_BIT_TIMER]) |=> !fault_reg[CTFS_BIT_TIMER])
    else $error("timer flag latched outside charge");
  a_timer_set_wins: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (rd_fault_w && chg_w && cond_w[CTFS_BIT_TIMER]) |=> fault_reg[CTFS_BIT_TIMER])
    else $error("timer flag lost while expired");
  a_pg_hysteresis: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (pg_active_w && meas_x100_w >= fall_w && meas_x100_w <= rise_w) |=> pg_reg == $past(pg_reg))
    else $error("power good left band early");
  a_pg_idle_zero: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    !pg_active_w |=> !pg_reg)
    else $error("power good set outside charge or reverse");
  a_reg_clear_wait: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_reg[CTFS_BIT_REG_FLT] && !reg_dly_done_w) |=> fault_reg[CTFS_BIT_REG_FLT])
    else $error("regulator flag cleared during delay");
  a_mask_ignored: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ((chg_w && regulator_fault_mask_charge_in) ||
     (rev_w && regulator_fault_mask_reverse_in)) && cond_w[CTFS_BIT_REG_FLT]
    |=> fault_reg[CTFS_BIT_REG_FLT])
    else $error("regulator flag suppressed by mask");
  a_sw_oc_hold: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_reg[CTFS_BIT_SW_OC] && cond_w[CTFS_BIT_SW_OC]) |=> fault_reg[CTFS_BIT_SW_OC])
    else $error("switch overcurrent cleared while present");
  a_ov_clear_wait: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (fault_reg[CTFS_BIT_IN_OV] && !ov_dly_done_w) |=> fault_reg[CTFS_BIT_IN_OV])
    else $error("input overvoltage cleared during delay");
  a_charge_stop_zone: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (chg_w && (rcold_w || rhot_w)) |=> charge_stop_out)
    else $error("charge not stopped in stop zone");
  a_reverse_stop_zone: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (rev_w && (rcold_w || rhot_w)) |=> reverse_stop_out)
    else $error("reverse not stopped in stop zone");
  a_profile_stop: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    (ccold_w || chot_w) |=> charge_stop_out)
    else $error("charge not stopped in cold or hot zone");
  a_cool_action: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    ccool_w |=> cool_action_out == $past(cool_action_in))
    else $error("cool action not applied");
  a_warm_action: assert property (@(posedge clock_in) disable iff (!rst_n_in)
    cwarm_w |=> warm_action_out == $past(warm_action_in))
    else $error("warm action not applied");
endmodule : ctfs_status

// ===== sim/ctfs_host_model.sv
`timescale 1ns/1ns
// ==========
// host side of the register port
module ctfs_host_model (
  input wire logic clock_in,
  input wire logic [7:0] reg_rdata_in,
  output logic [7:0] reg_addr_out,
  output logic reg_wr_out,
  output logic reg_rd_out,
  output logic [7:0] reg_wdata_out
);
  initial begin
    reg_addr_out = 8'h00;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_wdata_out = 8'h00;
  end
  // one register access, read or write
  // idle address and data are flipped so a stale value never looks live
  task automatic access(input logic wr, input logic [7:0] a, input logic [7:0] wd,
    output logic [7:0] rd);
    @(posedge clock_in);
    #2;
    reg_addr_out = a;
    reg_wdata_out = wd;
    reg_wr_out = wr;
    reg_rd_out = ~wr;
    @(posedge clock_in);
    #2;
    rd = reg_rdata_in;
    reg_wr_out = 1'b0;
    reg_rd_out = 1'b0;
    reg_addr_out = ~a;
    reg_wdata_out = ~wd;
  endtask : access
endmodule : ctfs_host_model

// ===== sim/tb_ctfs_status.sv
`timescale 1ns/1ns
`define CHK(g, e) begin checks++; if ((g) !== (e)) begin fail_count++; \
  $display("CHECK FAILED t=%0t got %h exp %h", $time, (g), (e)); end end
// ==========
// testbench
module tb_ctfs_status
  import ctfs_pkg::*;
;
  localparam logic [7:0] FA = CTFS_ADDR_FAULTS_A;
  localparam logic [7:0] TZ = CTFS_ADDR_TEMP_ZONE;
  logic clock_in = 1'b0;
  logic rst_n_in = 1'b0;
  int checks = 0;
  int fail_count = 0;
  logic [7:0] addr, wdata, rdata, d;
  logic rd_s, wr_s, tsoff, poff, csel, osel, mc, mr, bdet, irq_n, cstop, rstop;
  logic [1:0] mode, hsel, cact, cout;
  logic [3:0] wact, wout;
  logic signed [7:0] temp;
  logic [11:0] rtgt, vin, termination_voltage, vbat;
  logic [6:0] flt;
  // short restart delays keep the run brief
  ctfs_status #(.REG_RESTART_CYC(20), .OV_SLOW_CYC(10), .OV_FAST_CYC(3)) ctfs_status_inst (
    .clock_in(clock_in), .rst_n_in(rst_n_in), .reg_addr_in(addr), .reg_wr_in(wr_s),
    .reg_rd_in(rd_s), .reg_wdata_in(wdata), .reg_rdata_out(rdata), .op_mode_in(mode),
    .thermistor_sense_off_in(tsoff), .temp_profile_off_in(poff),
    .cold_threshold_select_in(csel), .hot_threshold_select_in(hsel), .cool_action_in(cact),
    .warm_action_in(wact), .overvoltage_restart_select_in(osel),
    .regulator_fault_mask_charge_in(mc), .regulator_fault_mask_reverse_in(mr),
    .battery_temp_in(temp), .battery_detect_in(bdet), .reverse_output_target_in(rtgt),
    .input_pin_volt_in(vin), .termination_voltage_in(termination_voltage), .battery_sense_pin_in(vbat),
    .timer_expired_in(flt[6]), .battery_ov_in(flt[5]), .regulator_fault_in(flt[4]),
    .die_overheat_in(flt[3]), .switch_oc_in(flt[2]), .input_ov_in(flt[1]),
    .input_uv_in(flt[0]), .interrupt_out_n(irq_n), .charge_stop_out(cstop),
    .reverse_stop_out(rstop), .cool_action_out(cout), .warm_action_out(wout));
  ctfs_host_model ctfs_host_model_inst (.clock_in(clock_in), .reg_rdata_in(rdata),
    .reg_addr_out(addr), .reg_wr_out(wr_s), .reg_rd_out(rd_s), .reg_wdata_out(wdata));
  always #25 clock_in = ~clock_in;
  task automatic tick(input int n);
    repeat (n) @(posedge clock_in);
    #2;
  endtask : tick
  task automatic rx(input logic [7:0] a, input logic [7:0] m, input logic [7:0] e);
    ctfs_host_model_inst.access(1'b0, a, 8'h00, d);
    `CHK(d & m, e)
  endtask : rx
  // inputs pass two sync flops and a register before the flags move
  task automatic zr(input logic [7:0] m, input logic [7:0] e);
    tick(5);
    rx(TZ, m, e);
  endtask : zr
  task automatic pulse(input logic [1:0] md, input int b, input logic e);
    mode = md;
    flt[b] = 1'b1;
    tick(5);
    flt[b] = 1'b0;
    tick(5);
    rx(FA, 8'h01 << b, e ? 8'h01 << b : 8'h00);
    rx(FA, 8'h01 << b, 8'h00);
  endtask : pulse
  task automatic hold(input logic [1:0] md, input int b);
    mode = md;
    flt[b] = 1'b1;
    tick(5);
    rx(FA, 8'h01 << b, 8'h01 << b);
    rx(FA, 8'h01 << b, 8'h01 << b);
    flt[b] = 1'b0;
    tick(5);
    rx(FA, 8'h01 << b, 8'h01 << b);
    rx(FA, 8'h01 << b, 8'h00);
  endtask : hold
  task automatic dly(input int b, input logic sel, input logic early, input int gap);
    osel = sel;
    flt[b] = 1'b1;
    tick(5);
    flt[b] = 1'b0;
    tick(4);
    if (early) begin
      rx(FA, 8'h01 << b, 8'h01 << b);
      rx(FA, 8'h01 << b, 8'h01 << b);
    end
    tick(gap);
    rx(FA, 8'h01 << b, 8'h01 << b);
    rx(FA, 8'h01 << b, 8'h00);
  endtask : dly
  task automatic t_reset();
    `CHK({irq_n, cstop, rstop, cout, wout}, 9'h100)
    `CHK(rdata, 8'h00)
    rx(FA, 8'hff, 8'h00);
    rx(TZ, 8'hff, 8'h00);
    rx(8'h09, 8'hff, 8'h00);
    $display("test reset done");
  endtask : t_reset
  task automatic t_levels();
    mode = CTFS_MODE_CHARGE;
    termination_voltage = 12'h3e8;
    vbat = 12'h399;
    zr(8'h80, 8'h80);
    vbat = 12'h389;
    zr(8'h80, 8'h80);
    vbat = 12'h383;
    zr(8'h80, 8'h00);
    mode = CTFS_MODE_REVERSE;
    rtgt = 12'h3e8;
    vin = 12'h399;
    vbat = 12'h000;
    zr(8'h80, 8'h80);
    vin = 12'h383;
    vbat = 12'h3e8;
    zr(8'h80, 8'h00);
    bdet = 1'b1;
    zr(8'h40, 8'h40);
    tsoff = 1'b1;
    zr(8'h40, 8'h00);
    $display("test levels done");
  endtask : t_levels
  task automatic t_zone();
    int tv[7] = '{-1, 0, 9, 10, 45, 60, 61};
    logic [3:0] zv[7] = '{4'h8, 4'h4, 4'h4, 4'h0, 4'h2, 4'h2, 4'h1};
    mode = CTFS_MODE_CHARGE;
    cact = 2'h2;
    wact = 4'h9;
    foreach (tv[i]) begin
      temp = 8'(tv[i]);
      zr(8'h3f, {4'h0, zv[i]});
      `CHK(cout, zv[i] == 4'h4 ? cact : 2'h0)
      `CHK(wout, zv[i] == 4'h2 ? wact : 4'h0)
      `CHK(cstop, zv[i][3] | zv[i][0])
    end
    poff = 1'b1;
    temp = -8'sh01;
    zr(8'h3f, 8'h20);
    `CHK(cstop, 1'b1)
    hsel = 2'h1;
    temp = 8'h3d;
    zr(8'h3f, 8'h10);
    `CHK(cstop, 1'b1)
    $display("test zone done");
  endtask : t_zone
  task automatic t_rev();
    int thr;
    mode = CTFS_MODE_REVERSE;
    for (int s = 0; s < 4; s++) begin
      hsel = 2'(s);
      thr = s == 0 ? CTFS_T_HOT55_C : s == 1 ? CTFS_T_HOT_C : CTFS_T_HOT65_C;
      temp = 8'(thr);
      zr(8'h30, 8'h00);
      temp = 8'(thr + 1);
      zr(8'h30, 8'h10);
      `CHK(rstop, 1'b1)
    end
    for (int s = 0; s < 2; s++) begin
      csel = s[0];
      thr = s == 0 ? CTFS_T_ZERO_C : CTFS_T_MINUS10_C;
      temp = 8'(thr);
      zr(8'h30, 8'h00);
      temp = 8'(thr - 1);
      zr(8'h30, 8'h20);
      `CHK(rstop, 1'b1)
    end
    temp = 8'h19;
    $display("test reverse done");
  endtask : t_rev
  task automatic t_faults();
    {mc, mr} = 2'h3;
    pulse(CTFS_MODE_CHARGE, CTFS_BIT_TIMER, 1'b1);
    pulse(CTFS_MODE_HIZ, CTFS_BIT_TIMER, 1'b0);
    pulse(CTFS_MODE_CHARGE, CTFS_BIT_BAT_OV, 1'b1);
    pulse(CTFS_MODE_CHARGE, CTFS_BIT_IN_UV, 1'b1);
    pulse(CTFS_MODE_REVERSE, CTFS_BIT_IN_UV, 1'b0);
    pulse(CTFS_MODE_REVERSE, CTFS_BIT_DIE_HOT, 1'b1);
    hold(CTFS_MODE_CHARGE, CTFS_BIT_TIMER);
    hold(CTFS_MODE_CHARGE, CTFS_BIT_DIE_HOT);
    hold(CTFS_MODE_REVERSE, CTFS_BIT_SW_OC);
    hold(CTFS_MODE_CHARGE, CTFS_BIT_IN_UV);
    mode = CTFS_MODE_CHARGE;
    dly(CTFS_BIT_REG_FLT, 1'b0, 1'b1, 30);
    dly(CTFS_BIT_IN_OV, 1'b0, 1'b1, 15);
    dly(CTFS_BIT_IN_OV, 1'b1, 1'b0, 4);
    $display("test faults done");
  endtask : t_faults
  task automatic t_irq();
    ctfs_host_model_inst.access(1'b1, FA, 8'h80, d);
    `CHK(irq_n, 1'b1)
    flt[CTFS_BIT_BAT_OV] = 1'b1;
    tick(5);
    flt[CTFS_BIT_BAT_OV] = 1'b0;
    tick(5);
    `CHK(irq_n, 1'b0)
    ctfs_host_model_inst.access(1'b1, FA, 8'h80, d);
    `CHK(irq_n, 1'b1)
    rx(FA, 8'hff, 8'h20);
    rx(FA, 8'hff, 8'h00);
    flt[CTFS_BIT_SW_OC] = 1'b1;
    tick(5);
    ctfs_host_model_inst.access(1'b1, FA, 8'h80, d);
    `CHK(irq_n, 1'b0)
    flt[CTFS_BIT_SW_OC] = 1'b0;
    tick(5);
    ctfs_host_model_inst.access(1'b1, FA, 8'h80, d);
    `CHK(irq_n, 1'b1)
    rx(FA, 8'hff, 8'h04);
    rx(FA, 8'hff, 8'h00);
    $display("test release done");
  endtask : t_irq
  task automatic results();
    $display("checks %0d mismatches %0d", checks, fail_count);
    if (fail_count == 0 && checks > 0) begin
      $display("Finished cleanly");
    end else begin
      $display("Finished with errors");
    end
    $finish;
  endtask : results
  initial begin
    #2000000;
    fail_count++;
    results();
  end
  initial begin
    {tsoff, poff, csel, osel, mc, mr, bdet} = 7'h00;
    {mode, hsel, cact} = 6'h00;
    wact = 4'h0;
    temp = 8'h19;
    {rtgt, vin, termination_voltage, vbat} = 48'h0;
    flt = 7'h00;
    repeat (2) @(posedge clock_in);
    #2;
    rst_n_in = 1'b1;
    t_reset();
    t_levels();
    t_zone();
    t_rev();
    t_faults();
    t_irq();
    results();
  end
endmodule : tb_ctfs_status
